// >>> pulse_actuator_model.sv
`timescale 1ns/100ps
module pulse_actuator_model
(
  // clock and clear
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  // pin from the generator
  input  wire logic        i_pin,
  // what the load saw
  output logic      [31:0] o_edges,
  output logic      [31:0] o_high
);
  logic        pin_q;
  logic [31:0] run_q;

  // load counts steps and times each high phase in clocks
  always_ff @(posedge i_clk)
  begin
    pin_q <= i_pin;
    if (i_clr)
    begin
      o_edges <= '0;
      o_high  <= '0;
      run_q   <= '0;
    end
    else if (i_pin && !pin_q)
    begin
      o_edges <= o_edges + 32'h1;
      run_q   <= 32'h1;
    end
    else if (i_pin)
      run_q <= run_q + 32'h1;
    else if (pin_q)
      o_high <= run_q;
  end
endmodule

// >>> pulse_cfg_if.sv
`timescale 1ns/100ps
interface pulse_cfg_if;
  import pulse_gen_pkg::*;
  chan_cfg_s cfg;
  logic      program_cmd;
  logic      image_bit;
  logic      active;
  logic      done;
  logic      level;
  modport ctl (output cfg, output program_cmd, output image_bit,
               input active, input done, input level);
  modport gen (input cfg, input program_cmd, input image_bit,
               output active, output done, output level);
endinterface

// >>> pulse_gen_core.sv
`timescale 1ns/100ps
`include "pulse_gen_defs.svh"
module pulse_gen_core
  import pulse_gen_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_us_tick,
  input  wire logic i_ms_tick,
  pulse_cfg_if.gen  io_cfg
);
  localparam logic [6:0] GAP_US = 7'(`GAP_US);

  gen_state_e  state_q;
  gen_state_e  state_d;
  logic [15:0] cycle_q;
  logic [15:0] cycle_d;
  logic [15:0] width_q;
  logic [15:0] width_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic [31:0] left_q;
  logic [31:0] left_d;
  logic [15:0] phase_q;
  logic [15:0] phase_d;
  logic [6:0]  gap_q;
  logic [6:0]  gap_d;
  logic        tbms_q;
  logic        tbms_d;
  logic        pwm_q;
  logic        pwm_d;
  logic        wave_q;
  logic        wave_d;
  logic        done_q;
  logic        done_d;
  logic        base_q;
  logic        base_d;
  logic        tick;
  logic [15:0] half;
  logic [7:0]  c;

  assign c    = io_cfg.cfg.ctrl;
  assign tick = tbms_q ? i_ms_tick : i_us_tick;
  assign half = {1'b0, cycle_q[15:1]};

  always_comb
  begin
    state_d = state_q;
    cycle_d = cycle_q;
    width_d = width_q;
    count_d = count_q;
    left_d  = left_q;
    phase_d = phase_q;
    gap_d   = gap_q;
    tbms_d  = tbms_q;
    pwm_d   = pwm_q;
    wave_d  = wave_q;
    base_d  = base_q;
    done_d  = 1'b0;
    if (io_cfg.program_cmd)
    begin
      // parameters reach the generator only here
      if (c[`CTL_UPD_CYCLE])
        cycle_d = (io_cfg.cfg.cycle < `CYCLE_MIN) ? `CYCLE_MIN : io_cfg.cfg.cycle;
      if (c[`CTL_UPD_WIDTH])
        width_d = io_cfg.cfg.width;
      if (c[`CTL_UPD_COUNT])
        count_d = io_cfg.cfg.count;
      tbms_d = c[`CTL_TBASE_MS];
      pwm_d  = c[`CTL_PWM];
      if (!c[`CTL_ENABLE])
        state_d = ST_IDLE;
      else if (state_q == ST_IDLE)
      begin
        // fresh start from the first pulse with last loaded values
        state_d = ST_RUN;
        left_d  = c[`CTL_UPD_COUNT] ? io_cfg.cfg.count : count_q;
        phase_d = 16'h0000;
        // base level latched so later image writes cannot bend the train
        base_d  = io_cfg.image_bit;
        // first half starts at once, before any tick, so pulse one can be up to a tick shorter than the rest
        wave_d  = c[`CTL_PWM] ? (width_d != 16'h0000) : ~io_cfg.image_bit;
      end
      else
      begin
        // on-the-fly change: brief disable window, then restart period
        state_d = ST_GAP;
        gap_d   = 7'h00;
        if (c[`CTL_UPD_COUNT])
          left_d = io_cfg.cfg.count;
        wave_d = pwm_q ? 1'b1 : wave_q;
      end
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          wave_d = io_cfg.image_bit;
        ST_GAP:
          if (i_us_tick)
          begin
            gap_d = gap_q + 7'h01;
            if (gap_q == GAP_US - 7'h01)
            begin
              state_d = ST_RUN;
              phase_d = 16'h0000;
              wave_d  = pwm_q ? 1'b1 : ~base_q;
            end
          end
        ST_RUN:
          if (tick)
          begin
            phase_d = (phase_q == cycle_q - 16'h0001) ? 16'h0000 : phase_q + 16'h0001;
            if (pwm_q)
              wave_d = (phase_d < width_q);
            else
            begin
              wave_d = (phase_d < half) ? ~base_q : base_q;
              if (phase_q == cycle_q - 16'h0001)
              begin
                left_d = left_q - 32'h0000_0001;
                if (left_q <= 32'h0000_0001)
                begin
                  state_d = ST_IDLE;
                  done_d  = 1'b1;
                  wave_d  = io_cfg.image_bit;
                end
              end
            end
          end
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_q <= ST_IDLE;
      cycle_q <= `CYCLE_RST;
      width_q <= `WIDTH_RST;
      count_q <= `COUNT_RST;
      left_q  <= 32'h0000_0000;
      phase_q <= 16'h0000;
      gap_q   <= 7'h00;
      tbms_q  <= 1'b0;
      pwm_q   <= 1'b0;
      wave_q  <= 1'b0;
      done_q  <= 1'b0;
      base_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cycle_q <= cycle_d;
      width_q <= width_d;
      count_q <= count_d;
      left_q  <= left_d;
      phase_q <= phase_d;
      gap_q   <= gap_d;
      tbms_q  <= tbms_d;
      pwm_q   <= pwm_d;
      wave_q  <= wave_d;
      done_q  <= done_d;
      base_q  <= base_d;
    end
  end

  property p_gap_holds_high;
    @(posedge i_clk) disable iff (i_srst)
    io_cfg.program_cmd && c[`CTL_ENABLE] && (state_q != ST_IDLE) && pwm_q
      |=> (state_q == ST_GAP) && wave_q;
  endproperty
  a_gap_holds_high: assert property (p_gap_holds_high) else $error("pwm gap not high");

  assign io_cfg.active = (state_q != ST_IDLE);
  assign io_cfg.done   = done_q;
  assign io_cfg.level  = wave_q;
endmodule

// >>> pulse_gen_defs.svh
`ifndef PULSE_GEN_DEFS_SVH
`define PULSE_GEN_DEFS_SVH

// apb byte offsets, channel 1 at +0x20
`define OFF_CTRL        12'h000
`define OFF_CYCLE       12'h004
`define OFF_WIDTH       12'h008
`define OFF_COUNT       12'h00c
`define OFF_CMD         12'h010
`define OFF_IMAGE       12'h014
`define OFF_STATUS      12'h018
`define CH_STRIDE_BIT   5

// control byte fields
`define CTL_UPD_CYCLE   0
`define CTL_UPD_WIDTH   1
`define CTL_UPD_COUNT   2
`define CTL_TBASE_MS    3
`define CTL_PWM         6
`define CTL_ENABLE      7

// reset values
`define CYCLE_RST       16'h0002
`define WIDTH_RST       16'h0000
`define COUNT_RST       32'h0000_0001

// timing: 125 MHz clock, 8 ns
`define CLK_NS          8
`define US_NS           1000
`define US_CYC          (`US_NS / `CLK_NS)
`define MS_PER_US       1000
`define GAP_US          120
`define CYCLE_MIN       16'h0002

`endif

// >>> pulse_gen_pkg.sv
package pulse_gen_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} gen_state_e;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] cycle;
    logic [15:0] width;
    logic [31:0] count;
  } chan_cfg_s;
endpackage

// >>> pulse_tick.sv
`timescale 1ns/100ps
`include "pulse_gen_defs.svh"
module pulse_tick
  import pulse_gen_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_srst,
  output logic      o_us_tick,
  output logic      o_ms_tick
);
  localparam logic [6:0] US_LAST = 7'(`US_CYC - 1);
  localparam logic [9:0] MS_LAST = 10'(`MS_PER_US - 1);

  logic [6:0] us_cnt_q;
  logic [6:0] us_cnt_d;
  logic [9:0] ms_cnt_q;
  logic [9:0] ms_cnt_d;
  logic       us_q;
  logic       us_d;
  logic       ms_q;
  logic       ms_d;

  always_comb
  begin
    us_d     = (us_cnt_q == US_LAST);
    us_cnt_d = us_d ? 7'h00 : us_cnt_q + 7'h01;
    ms_cnt_d = ms_cnt_q;
    ms_d     = 1'b0;
    if (us_d)
    begin
      ms_d     = (ms_cnt_q == MS_LAST);
      ms_cnt_d = ms_d ? 10'h000 : ms_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      us_cnt_q <= 7'h00;
      ms_cnt_q <= 10'h000;
      us_q     <= 1'b0;
      ms_q     <= 1'b0;
    end
    else
    begin
      us_cnt_q <= us_cnt_d;
      ms_cnt_q <= ms_cnt_d;
      us_q     <= us_d;
      ms_q     <= ms_d;
    end
  end

  assign o_us_tick = us_q;
  assign o_ms_tick = ms_q;

  property p_us_period;
    @(posedge i_clk) disable iff (i_srst)
    $rose(us_q) |=> !us_q [*8];
  endproperty
  a_us_period: assert property (p_us_period) else $error("us tick too frequent");
endmodule

// >>> pulse_train_and_pwm_output.sv
`timescale 1ns/100ps
`include "pulse_gen_defs.svh"
module pulse_train_and_pwm_output
  import pulse_gen_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // pins
  output logic             o_pulse_output_pin_a,
  output logic             o_pulse_output_pin_b,
  // events
  output logic [1:0]       o_train_complete
);
  logic us_tick;
  logic ms_tick;

  pulse_tick u_tick (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .o_us_tick (us_tick),
    .o_ms_tick (ms_tick)
  );

  logic        acc;
  logic        wr;
  logic        ch;
  logic [4:0]  reg_off;
  logic        hit;
  logic [1:0]  active;
  logic [1:0]  level;
  logic [1:0]  done;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;
  logic [7:0]  ctrl_q [2];
  logic [15:0] cycle_q [2];
  logic [15:0] width_q [2];
  logic [31:0] count_q [2];
  logic [1:0]  image_q;
  logic [1:0]  cmd_q;
  logic [1:0]  done_seen_q;
  logic        rdy_q;
  logic        rdy_d;

  assign acc     = i_psel && i_penable;
  // writes land only at the edge that completes the transfer, never twice
  assign wr      = acc && i_pwrite && rdy_q;
  assign ch      = i_paddr[`CH_STRIDE_BIT];
  assign reg_off = {i_paddr[4:2], 2'b00};
  assign hit     = (i_paddr[11:6] == 6'h00) && (reg_off <= `OFF_STATUS)
                   && (i_paddr[1:0] == 2'b00);

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_ch
      pulse_cfg_if cif ();
      logic        sel;
      logic [7:0]  ctrl_d;
      logic [15:0] cycle_d;
      logic [15:0] width_d;
      logic [31:0] count_d;
      logic        image_d;
      logic        cmd_d;
      logic        seen_d;

      assign sel = wr && hit && (ch == 1'(g));

      // staging registers; generator sees only the image bit until command
      always_comb
      begin
        ctrl_d  = ctrl_q[g];
        cycle_d = cycle_q[g];
        width_d = width_q[g];
        count_d = count_q[g];
        image_d = image_q[g];
        cmd_d   = 1'b0;
        seen_d  = done_seen_q[g] | done[g];
        if (sel)
        begin
          case (reg_off)
            `OFF_CTRL:  ctrl_d  = i_pwdata[7:0];
            `OFF_CYCLE: cycle_d = i_pwdata[15:0];
            `OFF_WIDTH: width_d = i_pwdata[15:0];
            `OFF_COUNT: count_d = i_pwdata;
            `OFF_CMD:   cmd_d   = i_pwdata[0];
            `OFF_IMAGE: image_d = i_pwdata[0];
            // write-1 clear; a completion in the same cycle wins
            `OFF_STATUS: seen_d = done[g] | (done_seen_q[g] & ~i_pwdata[1]);
            default: ctrl_d = ctrl_q[g];
          endcase
        end
      end

      always_ff @(posedge i_clk)
      begin
        if (i_srst)
        begin
          ctrl_q[g]      <= 8'h00;
          cycle_q[g]     <= `CYCLE_RST;
          width_q[g]     <= `WIDTH_RST;
          count_q[g]     <= `COUNT_RST;
          image_q[g]     <= 1'b0;
          cmd_q[g]       <= 1'b0;
          done_seen_q[g] <= 1'b0;
        end
        else
        begin
          ctrl_q[g]      <= ctrl_d;
          cycle_q[g]     <= cycle_d;
          width_q[g]     <= width_d;
          count_q[g]     <= count_d;
          image_q[g]     <= image_d;
          cmd_q[g]       <= cmd_d;
          done_seen_q[g] <= seen_d;
        end
      end

      assign cif.cfg.ctrl    = ctrl_q[g];
      assign cif.cfg.cycle   = cycle_q[g];
      assign cif.cfg.width   = width_q[g];
      assign cif.cfg.count   = count_q[g];
      assign cif.program_cmd = cmd_q[g];
      assign cif.image_bit   = image_q[g];
      assign active[g]       = cif.active;
      assign level[g]        = cif.level;
      assign done[g]         = cif.done;

      pulse_gen_core u_core (
        .i_clk     (i_clk),
        .i_srst    (i_srst),
        .i_us_tick (us_tick),
        .i_ms_tick (ms_tick),
        .io_cfg    (cif.gen)
      );

      // wave already tracks image when idle, so pin needs no mux glitch
      property p_idle_image;
        @(posedge i_clk) disable iff (i_srst)
        !active[g] && $stable(image_q[g]) && !cmd_q[g] && !$past(cmd_q[g])
          |=> level[g] == $past(image_q[g]);
      endproperty
      a_idle_image: assert property (p_idle_image) else $error("idle pin not image");
    end
  endgenerate

  // generator owns the pin while active
  assign o_pulse_output_pin_a = level[0];
  assign o_pulse_output_pin_b = level[1];
  assign o_train_complete     = done;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (acc && !hit)
      err_d = 1'b1;
    else if (acc && !i_pwrite)
    begin
      case (reg_off)
        `OFF_CTRL:   rdata_d = {24'h000000, ctrl_q[ch]};
        `OFF_CYCLE:  rdata_d = {16'h0000, cycle_q[ch]};
        `OFF_WIDTH:  rdata_d = {16'h0000, width_q[ch]};
        `OFF_COUNT:  rdata_d = count_q[ch];
        `OFF_IMAGE:  rdata_d = {31'h0, image_q[ch]};
        `OFF_STATUS: rdata_d = {29'h0, level[ch], done_seen_q[ch], active[ch]};
        default:     rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // one wait state: data comes from flip-flops
  assign rdy_d = acc && !rdy_q;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rdy_q <= 1'b0;
    else
      rdy_q <= rdy_d;
  end
  assign o_pready  = rdy_q;
  assign o_prdata  = rdata_q;
  assign o_pslverr = rdy_q && err_q;

  sequence s_prog_enable(int k);
    cmd_q[k] && ctrl_q[k][`CTL_ENABLE];
  endsequence

  property p_enable_starts;
    @(posedge i_clk) disable iff (i_srst)
    s_prog_enable(0) |=> active[0];
  endproperty
  a_enable_starts: assert property (p_enable_starts) else $error("enable not active");

  property p_disable_stops;
    @(posedge i_clk) disable iff (i_srst)
    cmd_q[0] && !ctrl_q[0][`CTL_ENABLE] |=> !active[0] ##1 level[0] == $past(image_q[0]);
  endproperty
  a_disable_stops: assert property (p_disable_stops) else $error("disable not immediate");

  property p_done_ends;
    @(posedge i_clk) disable iff (i_srst)
    done[0] |-> !active[0];
  endproperty
  a_done_ends: assert property (p_done_ends) else $error("done while active");

  property p_image_ignored;
    @(posedge i_clk) disable iff (i_srst)
    active[0] && !cmd_q[0] && !us_tick && !ms_tick
      |=> $stable(level[0]);
  endproperty
  a_image_ignored: assert property (p_image_ignored) else $error("image disturbed wave");

  property p_ready_once;
    @(posedge i_clk) disable iff (i_srst)
    o_pready |=> !o_pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held");

  // the master may only be answered after the setup and one access cycle
  sequence s_access_wait;
    acc && !rdy_q;
  endsequence

  property p_one_wait;
    @(posedge i_clk) disable iff (i_srst)
    s_access_wait |=> o_pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");

  property p_err_with_ready;
    @(posedge i_clk) disable iff (i_srst)
    o_pslverr |-> o_pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

  property p_unmapped_err;
    @(posedge i_clk) disable iff (i_srst)
    acc && rdy_q && !hit |-> o_pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  // a doubled command would turn a fresh start into an on-the-fly change
  property p_cmd_single;
    @(posedge i_clk) disable iff (i_srst)
    cmd_q[0] |=> !cmd_q[0];
  endproperty
  a_cmd_single: assert property (p_cmd_single) else $error("program command doubled");

  property p_image_write;
    @(posedge i_clk) disable iff (i_srst)
    wr && hit && !ch && (reg_off == `OFF_IMAGE) |=> image_q[0] == $past(i_pwdata[0]);
  endproperty
  a_image_write: assert property (p_image_write) else $error("image write lost");

  property p_ctrl_write;
    @(posedge i_clk) disable iff (i_srst)
    wr && hit && !ch && (reg_off == `OFF_CTRL) |=> ctrl_q[0] == $past(i_pwdata[7:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_width_write;
    @(posedge i_clk) disable iff (i_srst)
    wr && hit && !ch && (reg_off == `OFF_WIDTH) |=> width_q[0] == $past(i_pwdata[15:0]);
  endproperty
  a_width_write: assert property (p_width_write) else $error("width write lost");

  property p_count_write;
    @(posedge i_clk) disable iff (i_srst)
    wr && hit && !ch && (reg_off == `OFF_COUNT) |=> count_q[0] == $past(i_pwdata);
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  // set wins over a clear in the same cycle
  property p_sticky_set;
    @(posedge i_clk) disable iff (i_srst)
    done[0] |=> done_seen_q[0];
  endproperty
  a_sticky_set: assert property (p_sticky_set) else $error("complete not latched");

  property p_done_pulse;
    @(posedge i_clk) disable iff (i_srst)
    done[0] |=> !done[0];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("complete held");

  property p_start_level;
    @(posedge i_clk) disable iff (i_srst)
    s_prog_enable(0) ##0 (!active[0] && !ctrl_q[0][`CTL_PWM])
      |=> level[0] == !$past(image_q[0]);
  endproperty
  a_start_level: assert property (p_start_level) else $error("train start level");

  property p_enable_ch1;
    @(posedge i_clk) disable iff (i_srst)
    s_prog_enable(1) |=> active[1];
  endproperty
  a_enable_ch1: assert property (p_enable_ch1) else $error("second enable not active");
endmodule

// >>> tb.sv
`timescale 1ns/100ps
`include "pulse_gen_defs.svh"
module tb;
  import pulse_gen_pkg::*;
  logic        i_clk, i_srst, i_psel, i_penable, i_pwrite, clr, serr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, edges, high;
  logic        o_pready, o_pslverr, pin_a, pin_b;
  logic [1:0]  done;
  int          err_total, num_checks;
  logic [7:0]  ms_codes [3] = '{8'h8d, 8'h89, 8'h8c};

  pulse_train_and_pwm_output dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_pulse_output_pin_a(pin_a), .o_pulse_output_pin_b(pin_b), .o_train_complete(done));
  pulse_actuator_model load (.i_clk(i_clk), .i_clr(clr), .i_pin(pin_a), .o_edges(edges),
    .o_high(high));

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic bail(input string what);
    err_total++;
    $display("CHECK FAILED %s expected response seen none", what);
    tally_and_finish();
  endtask

  task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_rng(input string what, input int lo, input int hi, input logic [31:0] got);
    num_checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask

  // entered just after a rising edge; leaves one idle edge behind
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge i_clk);
      if (o_pready === 1'b1)
        break;
    end
    if (n == 20)
      bail("pready");
    rd = o_prdata;
    serr = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_eq(what, exp, rd);
  endtask

  task automatic clear_load();
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
  endtask

  task automatic wait_done(input int ch, input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge i_clk);
      if (done[ch] === 1'b1)
        break;
    end
    if (n == lim)
      bail("train complete");
    repeat (3) @(posedge i_clk);
  endtask

  // pin fed back as an edge input: new width loaded just after a rise
  task automatic sync_update(input logic [31:0] wd);
    int          n;
    logic [31:0] e;
    e = edges;
    for (n = 0; n < 1000; n++)
    begin
      @(posedge i_clk);
      if (edges !== e)
        break;
    end
    if (n == 1000)
      bail("pwm rising edge");
    wr(`OFF_WIDTH, wd);
    wr(`OFF_CTRL, 32'hc2);
    wr(`OFF_CMD, 32'h1);
  endtask

  initial
  begin
    err_total = 0;
    num_checks = 0;
    i_srst = 1'b1;
    clr = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = '0;
    i_pwdata = '0;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    clr <= 1'b0;
    @(posedge i_clk);
    rd_chk("cycle reset", `OFF_CYCLE, 32'h2);
    rd_chk("width reset", `OFF_WIDTH, 32'h0);
    rd_chk("count reset", `OFF_COUNT, 32'h1);
    rd_chk("status reset", `OFF_STATUS, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    check_eq("unmapped error", 32'h1, {31'h0, serr});
    check_eq("unmapped data", 32'h0, rd);
    // staged values must not move the pin before the command
    wr(`OFF_IMAGE, 32'h0);
    wr(`OFF_CYCLE, 32'h4);
    wr(`OFF_COUNT, 32'h3);
    wr(`OFF_CTRL, 32'h85);
    repeat (300) @(posedge i_clk);
    check_eq("staged edges", 32'h0, edges);
    wr(`OFF_CMD, 32'h1);
    wr(`OFF_IMAGE, 32'h1);
    // image held high across ticks must not bend the train
    repeat (300) @(posedge i_clk);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check_eq("active", 32'h1, {31'h0, rd[0]});
    wr(`OFF_IMAGE, 32'h0);
    wait_done(0, 3000);
    check_eq("train edges", 32'h3, edges);
    check_rng("half cycle", 249, 251, high);
    check_eq("idle pin", 32'h0, {31'h0, pin_a});
    rd_chk("complete sticky", `OFF_STATUS, 32'h2);
    wr(`OFF_STATUS, 32'h2);
    rd_chk("complete cleared", `OFF_STATUS, 32'h0);
    wr(`OFF_IMAGE, 32'h1);
    repeat (3) @(posedge i_clk);
    check_eq("image drives pin", 32'h1, {31'h0, pin_a});
    wr(`OFF_IMAGE, 32'h0);
    // cycle only: new count stays staged
    wr(`OFF_CYCLE, 32'h2);
    wr(`OFF_COUNT, 32'h5);
    wr(`OFF_CTRL, 32'h81);
    clear_load();
    wr(`OFF_CMD, 32'h1);
    wait_done(0, 3000);
    check_eq("cycle only edges", 32'h3, edges);
    check_rng("cycle only half", 124, 126, high);
    // count only: new cycle stays staged
    wr(`OFF_CYCLE, 32'h6);
    wr(`OFF_COUNT, 32'h2);
    wr(`OFF_CTRL, 32'h84);
    clear_load();
    wr(`OFF_CMD, 32'h1);
    wait_done(0, 3000);
    check_eq("count only edges", 32'h2, edges);
    check_rng("count only half", 124, 126, high);
    // abort mid train, then restart from the first pulse
    wr(`OFF_CYCLE, 32'h4);
    wr(`OFF_COUNT, 32'h4);
    wr(`OFF_CTRL, 32'h85);
    wr(`OFF_CMD, 32'h1);
    repeat (400) @(posedge i_clk);
    wr(`OFF_IMAGE, 32'h1);
    wr(`OFF_CTRL, 32'h00);
    wr(`OFF_CMD, 32'h1);
    repeat (3) @(posedge i_clk);
    check_eq("abort pin", 32'h1, {31'h0, pin_a});
    apb(1'b0, `OFF_STATUS, 32'h0);
    check_eq("abort idle", 32'h0, {31'h0, rd[0]});
    clear_load();
    wr(`OFF_CTRL, 32'h80);
    wr(`OFF_CMD, 32'h1);
    wait_done(0, 6000);
    check_eq("restart edges", 32'h4, edges);
    wr(`OFF_IMAGE, 32'h0);
    // millisecond tick codes: first half still running long after a us half
    foreach (ms_codes[i])
    begin
      wr(`OFF_CTRL, {24'h0, ms_codes[i]});
      wr(`OFF_CMD, 32'h1);
      repeat (300) @(posedge i_clk);
      check_eq("ms first half", 32'h1, {31'h0, pin_a});
      wr(`OFF_CTRL, 32'h00);
      wr(`OFF_CMD, 32'h1);
      repeat (3) @(posedge i_clk);
      check_eq("ms abort pin", 32'h0, {31'h0, pin_a});
    end
    // pwm with image high: one tick high in a four-tick period
    wr(`OFF_IMAGE, 32'h1);
    wr(`OFF_CYCLE, 32'h4);
    wr(`OFF_WIDTH, 32'h1);
    wr(`OFF_CTRL, 32'hc3);
    clear_load();
    wr(`OFF_CMD, 32'h1);
    repeat (1200) @(posedge i_clk);
    check_eq("pwm edges", 32'h2, edges);
    check_rng("pwm high", 124, 126, high);
    sync_update(32'h2);
    repeat (14000) @(posedge i_clk);
    check_eq("gap pin high", 32'h1, {31'h0, pin_a});
    apb(1'b0, `OFF_STATUS, 32'h0);
    check_eq("gap active", 32'h1, {31'h0, rd[0]});
    clear_load();
    repeat (2000) @(posedge i_clk);
    check_rng("new width high", 249, 251, high);
    wr(`OFF_CTRL, 32'h00);
    wr(`OFF_CMD, 32'h1);
    repeat (3) @(posedge i_clk);
    check_eq("pwm off pin", 32'h1, {31'h0, pin_a});
    wr(`OFF_IMAGE, 32'h0);
    // second channel runs one pulse
    wr(`OFF_CYCLE + 12'h020, 32'h2);
    wr(`OFF_COUNT + 12'h020, 32'h1);
    wr(`OFF_CTRL + 12'h020, 32'h85);
    wr(`OFF_CMD + 12'h020, 32'h1);
    wait_done(1, 2000);
    check_eq("second pin idle", 32'h0, {31'h0, pin_b});
    rd_chk("second complete", `OFF_STATUS + 12'h020, 32'h2);
    tally_and_finish();
  end
endmodule
